// ==== long_addr_alu_pkg.sv ====
// ****************************************
// operation codes and field positions
// ****************************************
package long_addr_alu_pkg;
  typedef enum logic [3:0] {
    OP_NONE,
    OP_STEP_DOWN_TO_WORKING,
    OP_STEP_UP_IN_PLACE,
    OP_STEP_UP_TO_WORKING,
    OP_BYTE_TRANSFER_TO_WORKING,
    OP_BYTE_TRANSFER_TO_MEMORY,
    OP_BITWISE_UNION_TO_WORKING,
    OP_BITWISE_UNION_TO_MEMORY,
    OP_ROTATE_UP_IN_PLACE,
    OP_ROTATE_UP_TO_WORKING,
    OP_ROTATE_UP_VIA_FLAG_IN_PLACE,
    OP_ROTATE_UP_VIA_FLAG_TO_WORKING
  } alu_op_t;
  localparam int BYTE_W = 8;
  localparam int MSB_POS = 7;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic FLAG_RESET = 1'b0;
endpackage : long_addr_alu_pkg

// ==== long_addr_alu_ops.sv ====
// Contract
// RL1 - step down: working = mem-1, zero flag only
// RL2 - step up in place: mem = mem+1, zero
// RL3 - step up to working: working = mem+1, zero
// RL4 - memory to working copy, no flags
// RL5 - working to memory copy, no flags
// RL6 - working = working OR mem, zero flag
// RL7 - mem = working OR mem, zero flag
// RL8 - rotate mem left in place, no flags
// RL9 - rotate mem left into working, no flags
// RL10 - rotate mem left through carry in place
// RL11 - rotate through carry into working, keep mem
// RL12 - zero flag set iff result is zero
`timescale 1ns/1ps
`default_nettype none
module long_addr_alu_ops
  import long_addr_alu_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // decoder request
  input wire logic op_valid_i,
  input wire alu_op_t op_i,
  // memory read data
  input wire logic [7:0] mem_rdata_i,
  // memory write port
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  // core state
  output logic [7:0] working_register_o,
  output logic zero_flag_o,
  output logic carry_flag_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] rot_up(input logic [7:0] b, input logic fill);
    rot_up = {b[MSB_POS-1:0], fill};
  endfunction : rot_up

  function automatic logic is_zero(input logic [7:0] b);
    is_zero = (b == BYTE_ZERO);
  endfunction : is_zero

  // ****************************************
  // next state
  // ****************************************
  logic [7:0] working, next_working, mem_wdata, next_mem_wdata;
  logic zero, next_zero, carry, next_carry, mem_we, next_mem_we;
  logic [7:0] res;

  always_comb begin
    next_working = working;
    next_zero = zero;
    next_carry = carry;
    next_mem_we = 1'b0;
    next_mem_wdata = mem_wdata;
    res = BYTE_ZERO;
    if (op_valid_i) begin
      case (op_i)
        OP_STEP_DOWN_TO_WORKING: begin
          res = mem_rdata_i - BYTE_ONE; // RL1
          next_working = res;
          next_zero = is_zero(res); // RL12
        end
        OP_STEP_UP_IN_PLACE: begin
          res = mem_rdata_i + BYTE_ONE; // RL2
          next_mem_we = 1'b1;
          next_mem_wdata = res;
          next_zero = is_zero(res); // RL12
        end
        OP_STEP_UP_TO_WORKING: begin
          res = mem_rdata_i + BYTE_ONE; // RL3
          next_working = res;
          next_zero = is_zero(res);
        end
        OP_BYTE_TRANSFER_TO_WORKING: begin
          next_working = mem_rdata_i; // RL4
        end
        OP_BYTE_TRANSFER_TO_MEMORY: begin
          next_mem_we = 1'b1; // RL5
          next_mem_wdata = working;
        end
        OP_BITWISE_UNION_TO_WORKING: begin
          res = working | mem_rdata_i; // RL6
          next_working = res;
          next_zero = is_zero(res);
        end
        OP_BITWISE_UNION_TO_MEMORY: begin
          res = working | mem_rdata_i; // RL7
          next_mem_we = 1'b1;
          next_mem_wdata = res;
          next_zero = is_zero(res);
        end
        OP_ROTATE_UP_IN_PLACE: begin
          next_mem_we = 1'b1; // RL8
          next_mem_wdata = rot_up(mem_rdata_i, mem_rdata_i[MSB_POS]);
        end
        OP_ROTATE_UP_TO_WORKING: begin
          next_working = rot_up(mem_rdata_i, mem_rdata_i[MSB_POS]); // RL9
        end
        OP_ROTATE_UP_VIA_FLAG_IN_PLACE: begin
          next_mem_we = 1'b1; // RL10
          next_mem_wdata = rot_up(mem_rdata_i, carry);
          next_carry = mem_rdata_i[MSB_POS];
        end
        OP_ROTATE_UP_VIA_FLAG_TO_WORKING: begin
          next_working = rot_up(mem_rdata_i, carry); // RL11
          next_carry = mem_rdata_i[MSB_POS];
        end
        default: begin
          next_working = working;
        end
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      working <= WORKING_RESET;
      zero <= FLAG_RESET;
      carry <= FLAG_RESET;
      mem_we <= 1'b0;
      mem_wdata <= BYTE_ZERO;
    end else begin
      working <= next_working;
      zero <= next_zero;
      carry <= next_carry;
      mem_we <= next_mem_we;
      mem_wdata <= next_mem_wdata;
    end
  end

  assign working_register_o = working;
  assign zero_flag_o = zero;
  assign carry_flag_o = carry;
  assign mem_we_o = mem_we;
  assign mem_wdata_o = mem_wdata;

  // ****************************************
  // checks
  // ****************************************
  step_down_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL1
    op_valid_i && op_i == OP_STEP_DOWN_TO_WORKING |=> working == $past(mem_rdata_i) - BYTE_ONE
    && !mem_we && carry == $past(carry))
    else $error("step down result wrong");
  step_up_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL2
    op_valid_i && op_i == OP_STEP_UP_IN_PLACE |=> mem_we && $stable(carry)
    && mem_wdata == $past(mem_rdata_i) + BYTE_ONE && working == $past(working))
    else $error("step up in place wrong");
  step_up_work_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL3
    op_valid_i && op_i == OP_STEP_UP_TO_WORKING |=> !mem_we && $stable(carry)
    && working == $past(mem_rdata_i) + BYTE_ONE)
    else $error("step up to working wrong");
  move_in_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL4
    op_valid_i && op_i == OP_BYTE_TRANSFER_TO_WORKING |=> working == $past(mem_rdata_i)
    && $stable(zero) && $stable(carry) && !mem_we)
    else $error("move to working wrong");
  move_out_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL5
    op_valid_i && op_i == OP_BYTE_TRANSFER_TO_MEMORY |=> mem_we
    && mem_wdata == $past(working) && $stable(zero) && $stable(carry))
    else $error("move to memory wrong");
  union_work_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL6
    op_valid_i && op_i == OP_BITWISE_UNION_TO_WORKING |=> working == ($past(working)
    | $past(mem_rdata_i)) && !mem_we)
    else $error("union to working wrong");
  union_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL7
    op_valid_i && op_i == OP_BITWISE_UNION_TO_MEMORY |=> mem_we
    && mem_wdata == ($past(working) | $past(mem_rdata_i)))
    else $error("union to memory wrong");
  rot_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL8
    op_valid_i && op_i == OP_ROTATE_UP_IN_PLACE |=> mem_we
    && mem_wdata == {$past(mem_rdata_i[MSB_POS-1:0]), $past(mem_rdata_i[MSB_POS])}
    && $stable(carry) && $stable(zero) && $stable(working))
    else $error("rotate in place wrong");
  rot_work_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL9
    op_valid_i && op_i == OP_ROTATE_UP_TO_WORKING |=> !mem_we
    && working == {$past(mem_rdata_i[MSB_POS-1:0]), $past(mem_rdata_i[MSB_POS])}
    && $stable(carry) && $stable(zero))
    else $error("rotate to working wrong");
  rotc_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL10
    op_valid_i && op_i == OP_ROTATE_UP_VIA_FLAG_IN_PLACE |=> mem_we
    && mem_wdata == {$past(mem_rdata_i[MSB_POS-1:0]), $past(carry)}
    && carry == $past(mem_rdata_i[MSB_POS]) && $stable(working))
    else $error("rotate via flag in place wrong");
  rotc_work_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL11
    op_valid_i && op_i == OP_ROTATE_UP_VIA_FLAG_TO_WORKING |=> !mem_we
    && working == {$past(mem_rdata_i[MSB_POS-1:0]), $past(carry)}
    && carry == $past(mem_rdata_i[MSB_POS]) && $stable(zero))
    else $error("rotate via flag to working wrong");
  zero_flag_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL12
    op_valid_i && (op_i == OP_STEP_UP_TO_WORKING || op_i == OP_BITWISE_UNION_TO_WORKING
    || op_i == OP_STEP_DOWN_TO_WORKING) |=> zero == (working == BYTE_ZERO))
    else $error("zero flag mismatch");
  zero_mem_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL12
    op_valid_i && (op_i == OP_STEP_UP_IN_PLACE || op_i == OP_BITWISE_UNION_TO_MEMORY)
    |=> zero == (mem_wdata == BYTE_ZERO))
    else $error("zero flag after memory write mismatch");

  // ****************************************
  // flag and state retention
  // ****************************************
  zero_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL12
    op_valid_i && (op_i == OP_BYTE_TRANSFER_TO_WORKING || op_i == OP_BYTE_TRANSFER_TO_MEMORY
    || op_i == OP_ROTATE_UP_IN_PLACE || op_i == OP_ROTATE_UP_TO_WORKING
    || op_i == OP_ROTATE_UP_VIA_FLAG_IN_PLACE || op_i == OP_ROTATE_UP_VIA_FLAG_TO_WORKING)
    |=> $stable(zero))
    else $error("zero flag changed by a non-affecting operation");
  carry_keep_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i) // RL4
    op_valid_i && op_i != OP_ROTATE_UP_VIA_FLAG_IN_PLACE
    && op_i != OP_ROTATE_UP_VIA_FLAG_TO_WORKING |=> $stable(carry))
    else $error("carry flag changed by a non-carry operation");
  idle_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
    !op_valid_i |=> !mem_we && $stable(working) && $stable(mem_wdata)
    && $stable(zero) && $stable(carry))
    else $error("state changed with no request");

endmodule : long_addr_alu_ops
`default_nettype wire

// ==== data_store.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// byte store behind the datapath
// ****************************************
module data_store (
  // clock
  input wire logic sys_clk_i,
  // access
  input wire logic req_i,
  input wire logic [3:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [16];
  logic [3:0] last_addr;
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = (i == 1) ? 8'h01 : 8'(i * 17);
  end
  // unselected read lines do not hold the byte
  assign rdata_o = req_i ? mem[addr_i] : ~mem[addr_i];
  always @(posedge sys_clk_i) begin
    if (req_i) last_addr <= addr_i;
    if (we_i) mem[last_addr] <= wdata_i;
  end
endmodule : data_store
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import long_addr_alu_pkg::*;
  logic sys_clk_i = 1'h0, rst_b_i = 1'h0, op_valid_i = 1'h0, taken = 1'h0;
  logic mem_we_o, zero_flag_o, carry_flag_o, z = 1'h0, c = 1'h0;
  alu_op_t op_i = OP_NONE;
  logic [3:0] addr = 4'h1;
  logic [7:0] mem_rdata_i, mem_wdata_o, working_register_o, w = 8'h00, wd = 8'h00;
  logic [7:0] mirror [16];
  logic [18:0] exp_q [$];
  logic [18:0] got;
  logic [31:0] lfsr = 32'h7565_7023;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  long_addr_alu_ops DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .mem_rdata_i(mem_rdata_i), .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o),
    .working_register_o(working_register_o), .zero_flag_o(zero_flag_o),
    .carry_flag_o(carry_flag_o));
  data_store store (.sys_clk_i(sys_clk_i), .req_i(op_valid_i), .addr_i(addr),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  task automatic check(input string what, input logic [18:0] seen, input logic [18:0] want);
    num_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic issue(input alu_op_t op, input logic v);
    logic [7:0] m, r;
    logic we, zu;
    m = mirror[addr];
    r = m;
    we = 1'h0;
    zu = 1'h0;
    op_valid_i = v;
    op_i = op;
    if (v) begin
      case (op)
        OP_STEP_DOWN_TO_WORKING: begin r = m - 8'h01; w = r; zu = 1'h1; end
        OP_STEP_UP_IN_PLACE: begin r = m + 8'h01; we = 1'h1; zu = 1'h1; end
        OP_STEP_UP_TO_WORKING: begin r = m + 8'h01; w = r; zu = 1'h1; end
        OP_BYTE_TRANSFER_TO_WORKING: w = m;
        OP_BYTE_TRANSFER_TO_MEMORY: begin r = w; we = 1'h1; end
        OP_BITWISE_UNION_TO_WORKING: begin r = w | m; w = r; zu = 1'h1; end
        OP_BITWISE_UNION_TO_MEMORY: begin r = w | m; we = 1'h1; zu = 1'h1; end
        OP_ROTATE_UP_IN_PLACE: begin r = {m[6:0], m[7]}; we = 1'h1; end
        OP_ROTATE_UP_TO_WORKING: begin r = {m[6:0], m[7]}; w = r; end
        OP_ROTATE_UP_VIA_FLAG_IN_PLACE: begin r = {m[6:0], c}; c = m[7]; we = 1'h1; end
        OP_ROTATE_UP_VIA_FLAG_TO_WORKING: begin r = {m[6:0], c}; c = m[7]; w = r; end
        default: ;
      endcase
      if (zu) z = (r == 8'h00);
      if (we) begin
        mirror[addr] = r;
        wd = r;
      end
      exp_q.push_back({we, wd, w, z, c});
    end
    @(posedge sys_clk_i);
    #1 addr = addr + 4'h1;
  endtask : issue
  // ****************************************
  // result watcher
  // ****************************************
  always @(posedge sys_clk_i) taken <= op_valid_i & rst_b_i;
  always @(negedge sys_clk_i) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      report_and_stop();
    end else if (taken && exp_q.size() > 0) begin
      got = {mem_we_o, mem_wdata_o, working_register_o, zero_flag_o, carry_flag_o};
      check("result", got, exp_q.pop_front());
    end else if (rst_b_i) begin
      check("idle write", {18'h0_0000, mem_we_o}, 19'h0_0000);
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    for (int i = 0; i < 16; i++) mirror[i] = (i == 1) ? 8'h01 : 8'(i * 17);
    repeat (12) @(posedge sys_clk_i);
    #1 rst_b_i = 1'h1;
    for (int k = 1; k < 12; k++) issue(alu_op_t'(k), 1'h1);
    for (int n = 0; n < 600; n++) begin
      lfsr = next_rand(lfsr);
      if (n == 400) begin
        op_valid_i = 1'h0;
        @(posedge sys_clk_i);
        #1 rst_b_i = 1'h0;
        #1 check("reset", {mem_we_o, mem_wdata_o, working_register_o, zero_flag_o,
          carry_flag_o}, 19'h0_0000);
        {w, wd, z, c} = 18'h0_0000;
        @(posedge sys_clk_i);
        #1 rst_b_i = 1'h1;
      end
      issue(alu_op_t'(4'(lfsr[7:0] % 8'h0C)), lfsr[9] | lfsr[10]);
    end
    op_valid_i = 1'h0;
    repeat (2) @(posedge sys_clk_i);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
